// *** quad_checker_properties.sv ***
// port assertions for the quadrature pulse output
`timescale 1ns/1ps
module quad_checker (
  // clock, reset and controller state
  input wire mclk,
  input wire rst_b,
  input wire run_state,
  input wire single_pulse_train_instr,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  // phase outputs
  input wire phase_a,
  input wire phase_b,
  input wire quad_owns_output
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  a_idle_low: assert property (!run_state [*3] |-> !phase_a && !phase_b)
    else $error("phase out of run");
  a_idle_owner: assert property (!run_state [*2] |-> !quad_owns_output)
    else $error("owner out of run");
  a_quarter_step: assert property ($rose(phase_a) |-> $stable(phase_b))
    else $error("both phases moved");
  a_lock_out: assert property (single_pulse_train_instr && !quad_owns_output |=> !quad_owns_output)
    else $error("lockout broken");
  a_start_claim: assert property (wr && addr == 4'h0 && wdata[0] && run_state
    && !single_pulse_train_instr ##1 run_state && !single_pulse_train_instr
    ##1 run_state && !single_pulse_train_instr |=> quad_owns_output)
    else $error("no claim");
  a_stop_output: assert property (wr && addr == 4'h0 && !wdata[0] && run_state |-> ##3 ($stable(phase_a) && $stable(phase_b)) [*4])
    else $error("no stop");
  a_read_slot: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("stray read data");
  a_quiet_unowned: assert property (!quad_owns_output [*3] |-> $stable(phase_a) && $stable(phase_b))
    else $error("phase moved unowned");
  cover property ($rose(phase_a) && !phase_b);
  cover property ($rose(phase_a) && phase_b);
  cover property ($rose(quad_owns_output));
endmodule // quad_checker
bind quadrature_pulse_output quad_checker chk_u (.mclk(mclk), .rst_b(rst_b),
  .run_state(run_state), .single_pulse_train_instr(single_pulse_train_instr), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .phase_a(phase_a), .phase_b(phase_b),
  .quad_owns_output(quad_owns_output));

// *** quad_drive.sv ***
// motor drive model decoding the phases into a signed position
`timescale 1ns/1ps
module quad_drive (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // phases and decoded position
  input wire phase_a,
  input wire phase_b,
  output int pos
);
  logic pa, pb;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pos <= 0;
      {pa, pb} <= 2'b00;
    end else begin
      {pa, pb} <= {phase_a, phase_b};
      // any edge is one step, its sign from which phase leads
      if ({phase_a, phase_b} != {pa, pb}) pos <= (phase_a != pb) ? pos + 1 : pos - 1;
    end
  end
endmodule // quad_drive

// *** quadrature_pulse_output.v ***
// quadrature (two-phase) pulse train generator with word register port
`timescale 1ns/1ps
`include "quadrature_pulse_output_regs.vh"
module quadrature_pulse_output (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // controller state
  input wire run_state,
  input wire scan_end,
  input wire single_pulse_train_instr,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // phase outputs
  output reg phase_a,
  output reg phase_b,
  output wire quad_owns_output
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg pulse_out_enable;
  reg continuous_run_select;
  reg target_reached_flag;
  reg [15:0] output_frequency;
  reg [15:0] phase_order_select;
  reg [31:0] target_count;
  reg [31:0] count;
  reg [31:0] present_count;
  reg enable_d;
  reg [1:0] owner;
  reg [1:0] quad_state;
  reg [31:0] tick_acc;
  reg [15:0] div_cnt;

  localparam OWN_NONE = 2'b00;
  localparam OWN_QUAD = 2'b01;
  localparam OWN_PULSE = 2'b10;

  wire editable = pulse_out_enable & ~target_reached_flag; // R06
  wire active = pulse_out_enable & run_state & (owner == OWN_QUAD) &
    (~target_reached_flag | continuous_run_select); // R15 R16 R14
  wire mode_write = wr & (addr == `ADDR_PHASE_ORDER) & editable &
    (wdata != phase_order_select);

  assign quad_owns_output = (owner == OWN_QUAD);

  function [15:0] clamp_freq;
    input [15:0] f;
    begin
      if (f < `FREQ_MIN_HZ) begin
        clamp_freq = `FREQ_MIN_HZ;
      end else if (f > `FREQ_MAX_HZ) begin
        clamp_freq = `FREQ_MAX_HZ;
      end else begin
        clamp_freq = f;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // ownership of output hardware
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      owner <= OWN_NONE;
    end else if (!run_state) begin
      owner <= OWN_NONE;
    end else if (owner == OWN_NONE) begin
      if (single_pulse_train_instr) begin
        owner <= OWN_PULSE; // R17
      end else if (pulse_out_enable) begin
        owner <= OWN_QUAD; // R17
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_out_enable <= 1'b0;
      continuous_run_select <= 1'b0;
      output_frequency <= `FREQ_RESET;
      phase_order_select <= `MODE_A_LEADS;
      target_count <= 32'h0000_0000;
    end else if (wr) begin
      case (addr)
        `ADDR_CONTROL: begin
          pulse_out_enable <= wdata[`CTRL_ENABLE_BIT];
          continuous_run_select <= wdata[`CTRL_CONTINUOUS_BIT];
        end
        `ADDR_FREQUENCY: begin
          if (editable) begin
            output_frequency <= clamp_freq(wdata); // R01 R06
          end
        end
        `ADDR_PHASE_ORDER: begin
          if (editable) begin
            phase_order_select <= wdata; // R02 R06
          end
        end
        `ADDR_TARGET_LOW: begin
          if (editable) begin
            target_count[15:0] <= wdata; // R12
          end
        end
        `ADDR_TARGET_HIGH: begin
          if (editable) begin
            target_count[31:16] <= wdata; // R12
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // tick divider: 80 kHz base at quarter-phase resolution
  // ----------------------------------------------------------------
  // the accumulator adds four times the frequency per tick, so a
  // quarter-period step occurs at 4*f per second
  reg step;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 16'h0000;
      tick_acc <= 32'h0000_0000;
      step <= 1'b0;
    end else begin
      step <= 1'b0;
      if (!active) begin
        div_cnt <= 16'h0000;
        tick_acc <= 32'h0000_0000;
      end else if (div_cnt == `TICK_DIV - 1) begin
        div_cnt <= 16'h0000;
        if (tick_acc + {14'h0000, output_frequency, 2'b00} >= `TICK_HZ) begin
          tick_acc <= tick_acc + {14'h0000, output_frequency, 2'b00} - `TICK_HZ; // R01
          step <= 1'b1;
        end else begin
          tick_acc <= tick_acc + {14'h0000, output_frequency, 2'b00};
        end
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // quadrature sequencer and counter
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      quad_state <= 2'b00;
      phase_a <= 1'b0;
      phase_b <= 1'b0;
      count <= 32'h0000_0000;
      target_reached_flag <= 1'b0;
      enable_d <= 1'b0;
    end else begin
      enable_d <= pulse_out_enable;
      if (!pulse_out_enable) begin
        target_reached_flag <= 1'b0; // R05
      end else if (count == target_count && !continuous_run_select &&
          enable_d && owner == OWN_QUAD) begin
        target_reached_flag <= 1'b1; // R04
      end
      if (pulse_out_enable && !enable_d) begin
        count <= 32'h0000_0000; // R10
      end else if (mode_write) begin
        count <= 32'h0000_0000; // R08
      end else if (active && step) begin
        count <= count + 32'h0000_0001; // R03 R07
        // b-leads walks the gray sequence backwards, so a mode change
        // never moves both phases at once
        if (phase_order_select == `MODE_B_LEADS) begin
          quad_state <= quad_state - 2'b01; // R02
        end else begin
          quad_state <= quad_state + 2'b01; // R02
        end
      end
      if (run_state && owner == OWN_QUAD) begin
        // gray sequence gives a quarter-period offset; a generator stopped in run
        // state holds its levels so the drive sees no false step
        phase_a <= quad_state[1] ^ quad_state[0]; // R18 R11
        phase_b <= quad_state[1];
      end else begin
        phase_a <= 1'b0; // R16
        phase_b <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // scan snapshot and read port
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      present_count <= 32'h0000_0000;
    end else if (scan_end || (pulse_out_enable && !enable_d)) begin
      present_count <= (pulse_out_enable && !enable_d) ? 32'h0000_0000 : count; // R09 R11
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `ADDR_CONTROL: rdata <= {12'h000, quad_owns_output, target_reached_flag,
          continuous_run_select, pulse_out_enable};
        `ADDR_FREQUENCY: rdata <= output_frequency;
        `ADDR_PHASE_ORDER: rdata <= phase_order_select;
        `ADDR_TARGET_LOW: rdata <= target_count[15:0];
        `ADDR_TARGET_HIGH: rdata <= target_count[31:16];
        `ADDR_PRESENT_LOW: rdata <= present_count[15:0]; // R13
        `ADDR_PRESENT_HIGH: rdata <= present_count[31:16]; // R13
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule // quadrature_pulse_output

// *** quadrature_pulse_output_regs.vh ***
// register map and timing constants of the quadrature pulse output
// Overview of operation
// R01: output period follows the frequency register; valid range 12 Hz to 20 kHz.
// R02: mode one makes phase A lead; mode two makes phase B lead.
// R03: present count rises by one on every phase edge, not per period.
// R04: present count reaching target count sets the target-reached flag; the code sets it only while the continuous switch is off.
// R05: target-reached flag clears only when the enable switch is turned off.
// R06: frequency, target and mode changes accepted while enabled and flag off.
// R07: frequency or target change leaves the present count unchanged.
// R08: mode change during operation resets the present count to zero.
// R09: software-visible present count refreshes once per scan.
// R10: enable going on clears the present count before counting.
// R11: enable going off stops output and keeps the last count.
// R12: target count is 32 bits, low word first, high word second.
// R13: present count is 32 bits, low word first, high word second.
// R14: continuous switch on keeps pulses running past the target.
// R15: enable switch starts generation; dropping it stops generation.
// R16: generator runs only in controller run state; otherwise output inhibited.
// R17: quadrature output and single pulse train exclude each other; first claimer wins.
// R18: A and B are equal-period squares offset by a quarter period.
`ifndef QUADRATURE_PULSE_OUTPUT_REGS_VH
`define QUADRATURE_PULSE_OUTPUT_REGS_VH
`define ADDR_CONTROL 4'h0
`define ADDR_FREQUENCY 4'h1
`define ADDR_PHASE_ORDER 4'h2
`define ADDR_TARGET_LOW 4'h3
`define ADDR_TARGET_HIGH 4'h4
`define ADDR_PRESENT_LOW 4'h5
`define ADDR_PRESENT_HIGH 4'h6
`define CTRL_ENABLE_BIT 0
`define CTRL_CONTINUOUS_BIT 1
`define CTRL_REACHED_BIT 2
`define CTRL_OWNED_BIT 3
`define MODE_A_LEADS 16'h0001
`define MODE_B_LEADS 16'h0002
`define FREQ_MIN_HZ 16'h000c
`define FREQ_MAX_HZ 16'h4e20
`define FREQ_RESET 16'h03e8
`define CLOCK_HZ 100000000
`define TICK_HZ 32'd80000
`define TICK_DIV (`CLOCK_HZ / 80000)
`endif

// *** testbench.sv ***
// self-checking bench for the quadrature pulse output
`timescale 1ns/1ps
module testbench;
  reg mclk = 1'b0, rst_b = 1'b0, run_state = 1'b0, scan_end = 1'b0;
  reg single_pulse_train_instr = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000, v;
  wire [15:0] rdata;
  wire phase_a, phase_b, quad_owns_output;
  int pos, p0, t, err_total = 0, n_tests = 0;
  quadrature_pulse_output dut_u (.mclk(mclk), .rst_b(rst_b), .run_state(run_state),
    .scan_end(scan_end), .single_pulse_train_instr(single_pulse_train_instr), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .phase_a(phase_a), .phase_b(phase_b),
    .quad_owns_output(quad_owns_output));
  quad_drive drive_u (.mclk(mclk), .rst_b(rst_b), .phase_a(phase_a), .phase_b(phase_b),
    .pos(pos));
  always #5 mclk = ~mclk;
  task automatic chk(input [15:0] got, input [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input [3:0] a, input [15:0] d);
    @(posedge mclk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input [3:0] a);
    @(posedge mclk);
    {addr, rd} <= {a, 1'b1};
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(input [3:0] a, input [15:0] exp);
    rreg(a);
    chk(v, exp);
  endtask
  task automatic scan();
    @(posedge mclk);
    scan_end <= 1'b1;
    @(posedge mclk);
    scan_end <= 1'b0;
  endtask
  task automatic results();
    $display("errors %0d, comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    t = $urandom(74833);
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(i[3:0], i == 1 ? 16'h03e8 : {15'h0, i == 2});
    wreg(4'h1, 16'($urandom));
    rchk(4'h1, 16'h03e8);
    run_state <= 1'b1;
    for (int m = 1; m < 3; m++) begin
      t = $urandom % 8 + 3;
      p0 = pos;
      wreg(4'h0, 16'h0003);
      wreg(4'h2, m[15:0]);
      wreg(4'h1, 16'h0000);
      rchk(4'h1, 16'h000c);
      wreg(4'h4, 16'h0000);
      wreg(4'h3, t[15:0]);
      rchk(4'h0, 16'h000b);
      wreg(4'h1, 16'hffff);
      rchk(4'h1, 16'h4e20);
      wreg(4'h0, 16'h0001);
      v = 16'h0000;
      for (int k = 0; k < 20000 && !v[2]; k++) rreg(4'h0);
      if (!v[2]) begin
        err_total++;
        results();
      end
      chk(16'(pos - p0), m == 1 ? t[15:0] : 16'(-t));
      rchk(4'h0, 16'h000d);
      rchk(4'h5, 16'h0000);
      wreg(4'h1, 16'h0100);
      rchk(4'h1, 16'h4e20);
      scan();
      rchk(4'h5, t[15:0]);
      rchk(4'h6, 16'h0000);
      wreg(4'h0, 16'h0000);
      rreg(4'h0);
      chk({13'h0, v[2:0]}, 16'h0000);
      scan();
      rchk(4'h5, t[15:0]);
    end
    run_state <= 1'b0;
    single_pulse_train_instr <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({14'h0, phase_a, phase_b}, 16'h0000);
    run_state <= 1'b1;
    wreg(4'h0, 16'h0001);
    repeat (3) @(posedge mclk);
    chk({15'h0, quad_owns_output}, 16'h0000);
    results();
  end
endmodule // testbench
